// file: rtl/kbd_ctrl.sv
/*
 * Keyboard serial controller: receives framed bytes from the keyboard,
 * checks parity, translates them into an output buffer, and sends host
 * bytes with odd parity once the previous one has been acknowledged or has timed out.
 * Assumes the keyboard drives the link clock, both pins are open drain
 * with board pull-ups, and the host side logic runs on CLK.
 */
// How it works
// - Receive keyboard serial characters and check each one's parity.
// - Translate the scan code and hold the result in the output buffer.
// - Raise an interrupt while the output buffer holds a byte.
// - Status flags let the host poll for an available byte.
// - A byte written by the host is sent to the keyboard.
// - Sent bytes go out serially with odd parity appended.
// - Next byte is taken only after the previous one was acknowledged or timed out.
// - The buffer-full interrupt paces receive handling only; sending is paced by TX_BUSY.
`timescale 1ns/1ps
`default_nettype none
module kbd_ctrl #(
    parameter int ACK_WAIT = kbd_pkg::ACK_WAIT_CYC
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic KCLK_IN,
    output logic KCLK_OUT,
    output logic KCLK_OE,
    input wire logic KDAT_IN,
    output logic KDAT_OUT,
    output logic KDAT_OE,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_WRITE,
    output logic TX_BUSY,
    output logic TX_TIMEOUT,
    input wire logic RD_ACK,
    output logic [7:0] RX_DATA,
    output logic RX_FULL,
    output logic RX_PAR_ERR,
    output logic IRQ
);
    typedef struct packed {
        logic [1:0] kclk_s;
        logic [1:0] kdat_s;
        logic kclk_d;
        logic [3:0] rx_cnt;
        logic [10:0] rx_sh;
        logic xl_pend;
        logic xl_perr;
        logic xl_go;
        kbd_pkg::obuf_t obuf;
        kbd_pkg::tx_state_t tx_st;
        logic [3:0] tx_cnt;
        logic [10:0] tx_sh;
        logic [7:0] tx_hold;
        logic tx_pend;
        logic tx_to;
        logic [31:0] wait_cnt;
        logic kdat_oe;
        logic irq;
        logic busy;
        // Pin drive registers; the clock pair is never driven.
        logic kclk_out;
        logic kclk_oe;
        logic kdat_out;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [7:0] xl_data;
    logic fall;
    logic [7:0] rx_byte;

    // Odd parity bit for a byte: set when the byte has an even count of ones.
    function automatic logic odd_par(input logic [7:0] d);
        return ~(^d);
    endfunction

    // True on the last bit of an eleven bit frame, stop bit included.
    function automatic logic is_last(input logic [3:0] cnt);
        return cnt == kbd_pkg::LAST_BIT;
    endfunction

    // Eleven bit frame as it leaves the shifter, start bit first.
    function automatic logic [10:0] tx_frame(input logic [7:0] d);
        return {1'b1, odd_par(d), d, 1'b0};
    endfunction

    // Data plus parity with an even count of ones is a parity error.
    function automatic logic rx_par_bad(input logic [8:0] dp);
        return (^dp) == 1'b0;
    endfunction

    // The data byte sits between the start bit and the parity bit.
    assign rx_byte = st_r.rx_sh[8:1];

    // The table answers one cycle after the byte settles, hence xl_go.
    kbd_xlate u_xlate (
        .clk(CLK),
        .rstn(RSTN),
        .addr(rx_byte),
        .data(xl_data)
    );

    // Only the second synchroniser stage feeds the edge detector.
    assign fall = st_r.kclk_d & ~st_r.kclk_s[1];

    always_comb begin
        st_nxt = st_r;
        st_nxt.kclk_s = {st_r.kclk_s[0], KCLK_IN};
        st_nxt.kdat_s = {st_r.kdat_s[0], KDAT_IN};
        st_nxt.kclk_d = st_r.kclk_s[1];
        st_nxt.xl_go = 1'b0;
        // A receive frame only runs while the transmitter is not shifting.
        if (fall && st_r.tx_st != kbd_pkg::TX_SHIFT) begin
            st_nxt.rx_sh = {st_r.kdat_s[1], st_r.rx_sh[10:1]};
            // A high start bit is noise; the frame counter stays at zero.
            if (st_r.rx_cnt == 4'h0 && st_r.kdat_s[1]) begin
                st_nxt.rx_cnt = 4'h0;
            end else if (is_last(st_r.rx_cnt)) begin
                st_nxt.rx_cnt = 4'h0;
                st_nxt.xl_pend = 1'b1;
            end else begin
                st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
            end
        end
        if (st_r.xl_pend) begin
            st_nxt.xl_pend = 1'b0;
            st_nxt.xl_go = 1'b1;
            st_nxt.xl_perr = rx_par_bad(st_r.rx_sh[9:1]);
            // An acknowledge byte from the keyboard also lands in the buffer.
            if (st_r.tx_st == kbd_pkg::TX_WAIT_ACK
                    && rx_byte == kbd_pkg::ACK_CODE) begin
                st_nxt.tx_st = kbd_pkg::TX_IDLE;
            end
        end
        // A full buffer is not overwritten; the host must read it first.
        if (RD_ACK) begin
            st_nxt.obuf.full = 1'b0;
        end
        if (st_r.xl_go && !st_r.obuf.full) begin
            st_nxt.obuf.data = xl_data;
            st_nxt.obuf.par_err = st_r.xl_perr;
            st_nxt.obuf.full = 1'b1;
        end
        st_nxt.irq = st_nxt.obuf.full;
        // A write is only taken while nothing is pending, sending or
        // awaiting its acknowledge; later writes are ignored.
        if (TX_WRITE && !st_r.busy) begin
            st_nxt.tx_hold = TX_DATA;
            st_nxt.tx_pend = 1'b1;
        end
        case (st_r.tx_st)
            kbd_pkg::TX_IDLE: begin
                // Sending waits for the receiver to be between frames.
                if (st_r.tx_pend && st_r.rx_cnt == 4'h0) begin
                    st_nxt.tx_sh = tx_frame(st_r.tx_hold);
                    st_nxt.tx_pend = 1'b0;
                    st_nxt.tx_to = 1'b0;
                    st_nxt.tx_cnt = 4'h0;
                    st_nxt.kdat_oe = 1'b1;
                    st_nxt.tx_st = kbd_pkg::TX_SHIFT;
                end
            end
            kbd_pkg::TX_SHIFT: begin
                if (fall) begin
                    st_nxt.tx_sh = {1'b1, st_r.tx_sh[10:1]};
                    if (is_last(st_r.tx_cnt)) begin
                        st_nxt.kdat_oe = 1'b0;
                        st_nxt.wait_cnt = 32'h0;
                        st_nxt.tx_st = kbd_pkg::TX_WAIT_ACK;
                    end else begin
                        // A zero in the next position pulls the line low.
                        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
                        st_nxt.kdat_oe = ~st_r.tx_sh[1];
                    end
                end
            end
            kbd_pkg::TX_WAIT_ACK: begin
                // Without a timeout a dead keyboard would block sending.
                st_nxt.wait_cnt = st_r.wait_cnt + 32'h1;
                if (st_r.wait_cnt == 32'(ACK_WAIT - 1)) begin
                    st_nxt.tx_to = 1'b1;
                    st_nxt.tx_st = kbd_pkg::TX_IDLE;
                end
            end
            default: begin
                st_nxt.tx_st = kbd_pkg::TX_IDLE;
            end
        endcase

        // Busy is kept as a register so the host sees a clean level.
        st_nxt.busy = st_nxt.tx_pend
            || st_nxt.tx_st != kbd_pkg::TX_IDLE;
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            // Link lines idle high, so no false edge follows reset.
            st_r <= '0;
            st_r.kclk_s <= 2'h3;
            st_r.kdat_s <= 2'h3;
            st_r.kclk_d <= 1'b1;
            st_r.tx_st <= kbd_pkg::TX_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The clock pin is never driven: the keyboard owns the link clock,
    // so its drive registers stay at zero. Data is only pulled low;
    // ones are released to the pull-up.
    assign KDAT_OUT = st_r.kdat_out;
    assign KCLK_OUT = st_r.kclk_out;
    assign KCLK_OE = st_r.kclk_oe;
    assign KDAT_OE = st_r.kdat_oe;
    assign TX_BUSY = st_r.busy;
    assign TX_TIMEOUT = st_r.tx_to;
    assign RX_DATA = st_r.obuf.data;
    assign RX_FULL = st_r.obuf.full;
    assign RX_PAR_ERR = st_r.obuf.par_err;
    assign IRQ = st_r.irq;
endmodule // kbd_ctrl
`default_nettype wire

// file: rtl/kbd_xlate.sv
/*
 * Scan code translation table held in a small registered memory.
 * Assumes the read address is stable for one cycle before data is used.
 */
`timescale 1ns/1ps
`default_nettype none
module kbd_xlate (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    output logic [7:0] data
);
    logic [7:0] mem [256];

    // Identity table with a neutral mask; a real map would be loaded here.
    always_comb begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ kbd_pkg::SCAN_XOR;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data <= 8'h00;
        end else begin
            data <= mem[addr];
        end
    end
endmodule // kbd_xlate
`default_nettype wire

// file: shared/kbd_pkg.sv
/*
 * Constants and carrier types for the keyboard serial controller.
 * Assumes a 200 MHz core clock and a keyboard that drives the link clock.
 */
`default_nettype none
package kbd_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FRAME_BITS = 11;
    localparam logic [3:0] LAST_BIT = 4'hA;
    localparam logic [3:0] PARITY_POS = 4'h9;
    // Time allowed for the keyboard to answer a sent byte, in microseconds.
    localparam int ACK_WAIT_US = 20000;
    localparam int ACK_WAIT_CYC = ACK_WAIT_US * 1000 / CLK_PERIOD_NS;
    localparam logic [7:0] SCAN_XOR = 8'h00;
    localparam logic [7:0] ACK_CODE = 8'hFA;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_WAIT_ACK} tx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic par_err;
        logic full;
    } obuf_t;
endpackage
`default_nettype wire

// file: testbench/kbd_ctrl_assertions.sv
/* Checker for kbd_ctrl port behaviour.
   Assumes it is bound to kbd_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module kbd_ctrl_checker (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic TX_WRITE,
    input wire logic TX_BUSY,
    input wire logic TX_TIMEOUT,
    input wire logic KDAT_OE,
    input wire logic KDAT_OUT,
    input wire logic KCLK_OE,
    input wire logic KCLK_OUT,
    input wire logic RD_ACK,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_FULL,
    input wire logic IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    property p_irq; IRQ == RX_FULL; endproperty
    a_irq: assert property (p_irq) else $error("irq not full");
    property p_hold; RX_FULL && !RD_ACK |=> RX_FULL && $stable(RX_DATA);
    endproperty
    a_hold: assert property (p_hold) else $error("byte lost");
    property p_clr; RX_FULL && RD_ACK |=> !RX_FULL; endproperty
    a_clr: assert property (p_clr) else $error("full stuck");
    property p_take; TX_WRITE && !TX_BUSY |=> TX_BUSY; endproperty
    a_take: assert property (p_take) else $error("write lost");
    property p_start; TX_WRITE && !TX_BUSY |-> ##2 KDAT_OE; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_oe; KDAT_OE |-> TX_BUSY; endproperty
    a_oe: assert property (p_oe) else $error("drive idle");
    property p_pins; !KCLK_OE && !KCLK_OUT && !KDAT_OUT; endproperty
    a_pins: assert property (p_pins) else $error("pin driven");
    property p_to; $rose(TX_TIMEOUT) |-> $past(TX_BUSY) && !TX_BUSY;
    endproperty
    a_to: assert property (p_to) else $error("bad timeout");
endmodule // kbd_ctrl_checker
bind kbd_ctrl kbd_ctrl_checker chk_i (.CLK, .RSTN, .TX_WRITE, .TX_BUSY,
    .TX_TIMEOUT, .KDAT_OE, .KDAT_OUT, .KCLK_OE, .KCLK_OUT, .RD_ACK,
    .RX_DATA, .RX_FULL, .IRQ);
`default_nettype wire

// file: testbench/kbd_partner.sv
/* Keyboard model: clocks every frame itself.
   Assumes a pulled-up data line. */
`timescale 1ns/1ps
`default_nettype none
module kbd_partner (
    output logic kclk,
    output logic kdat,
    input wire logic line
);
    initial begin
        kclk = 1'h1;
        kdat = 1'h1;
    end
    // Clock stays high between frames; data released to the pull-up.
    task automatic frame(input logic [10:0] b, output logic [10:0] g);
        for (int i = 0; i < 11; i++) begin
            kdat = b[i];
            #24 kclk = 1'h0;
            g[i] = line;
            #24 kclk = 1'h1;
        end
        kdat = 1'h1;
    endtask
    task automatic send(input logic [7:0] d, input logic bad);
        logic [10:0] g;
        frame({1'h1, ~^d ^ bad, d, 1'h0}, g);
    endtask
    task automatic recv(output logic [10:0] g);
        frame(11'h7FF, g);
    endtask
endmodule // kbd_partner
`default_nettype wire

// file: testbench/keyboard_serial_controller_bench.sv
/* Bench for kbd_ctrl: receive, send, refusal, timeout.
   Assumes kbd_partner as the keyboard. */
`timescale 1ns/1ps
`default_nettype none
module keyboard_serial_controller_bench;
    logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd_ack = 1'h0;
    logic [7:0] txd = 8'h00;
    logic [7:0] rx_data;
    logic [10:0] g;
    logic kclk, kdat, kclk_oe, tx_busy, tx_to, kdat_oe, rx_full, perr, irq;
    int miscompares = 0, samples_checked = 0;
    wire logic line = kdat & ~kdat_oe;
    wire logic kline = kclk & ~kclk_oe;
    kbd_ctrl #(.ACK_WAIT(2000)) dut (.CLK(clk), .RSTN(rstn), .KCLK_IN(kline),
        .KCLK_OUT(), .KCLK_OE(kclk_oe), .KDAT_IN(line), .KDAT_OUT(),
        .KDAT_OE(kdat_oe), .TX_DATA(txd), .TX_WRITE(wr), .TX_BUSY(tx_busy),
        .TX_TIMEOUT(tx_to), .RD_ACK(rd_ack), .RX_DATA(rx_data),
        .RX_FULL(rx_full), .RX_PAR_ERR(perr), .IRQ(irq));
    kbd_partner kb (.kclk(kclk), .kdat(kdat), .line(line));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [10:0] s, input logic [10:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: %0h vs %0h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic put(input logic [7:0] d);
        @(negedge clk);
        txd = d;
        wr = 1'h1;
        @(negedge clk);
        wr = 1'h0;
    endtask
    task automatic get(input logic [7:0] d, input logic bad);
        kb.send(d, bad);
        repeat (6) @(negedge clk);
    endtask
    task automatic pulse_rd;
        @(negedge clk);
        rd_ack = 1'h1;
        @(negedge clk);
        rd_ack = 1'h0;
    endtask
    task automatic t_rx;
        get(8'h5A, 1'h0);
        chk({rx_full, irq, perr, rx_data}, {3'h6, 8'h5A ^ kbd_pkg::SCAN_XOR});
        get(8'h33, 1'h0);
        chk(rx_data, 8'h5A ^ kbd_pkg::SCAN_XOR);
        pulse_rd;
        chk(rx_full, 1'h0);
        get(8'hC3, 1'h1);
        chk({irq, perr}, 2'h3);
        pulse_rd;
        $display("receive test done");
    endtask
    task automatic t_tx;
        put(8'hA5);
        put(8'h11);
        chk({tx_busy, kdat_oe}, 2'h3);
        kb.recv(g);
        chk(g, {1'h1, ~^8'hA5, 8'hA5, 1'h0});
        chk(tx_busy, 1'h1);
        get(kbd_pkg::ACK_CODE, 1'h0);
        chk(tx_busy, 1'h0);
        pulse_rd;
        $display("send test done");
    endtask
    task automatic t_to;
        put(8'h0F);
        kb.recv(g);
        for (int i = 0; i < 2100 && tx_to !== 1'h1; i++) @(negedge clk);
        chk({tx_to, tx_busy}, 2'h2);
        $display("timeout test done");
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rstn = 1'h1;
        repeat (3) @(negedge clk);
        t_rx;
        t_tx;
        t_to;
        tally_and_finish;
    end
    initial begin
        #60000;
        miscompares++;
        tally_and_finish;
    end
endmodule // keyboard_serial_controller_bench
`default_nettype wire
